// [core/cra_pkg.sv]
// Constants for the configuration register access block.
// Assumes a host I/O cycle port synchronous to ref_clk_i.
// Summary of operation
// - Registers are reached through the processor I/O address space.
// - Internal registers form three sets: hub, graphics bridge, streaming port.
// - Configuration access uses mechanism one: address port plus data window.
// - Byte, word and dword accesses touch only the addressed bytes.
// - Multi-byte fields are little-endian, low byte at lowest address.
// - Writes to read-only bits are ignored but the cycle completes.
// - Writing one clears a write-one-clear bit; zero leaves it.
// - Write-once bits take only the first write after power-up.
// - Lockable bits become read-only once their lock bit is set.
// - Reserved hub locations still complete the host cycle normally.
// - Reads of reserved locations return zero across the access width.
// - Writes to reserved locations change no internal state.
// - Full reset loads every register with its predetermined default.
// - Some reset defaults come from strapped input levels.
// - Address port sits at I/O address 0CF8h, written as dword.
// - Data window 0CFCh to 0CFFh produces a configuration cycle.
// - Configuration cycle only when address port bit 31 is one.
// - Full reset restores every default; warm reset keeps the sticky control bits and the write-once bits.
package cra_pkg;

  // ***********************************************************
  // I/O port map
  // ***********************************************************
  localparam logic [15:0] CRA_IO_ADDR_PORT = 16'h0CF8;
  localparam logic [15:0] CRA_IO_DATA_PORT = 16'h0CFC;
  localparam logic [31:0] CRA_ADDR_KEEP    = 32'h80FF_FFFC; // Bits held by the address port
  localparam int          CRA_ENABLE_BIT   = 31;
  localparam int          CRA_BUS_LSB      = 16;
  localparam int          CRA_DEV_LSB      = 11;
  localparam int          CRA_FUNC_LSB     = 8;
  localparam int          CRA_REG_LSB      = 2;

  // ***********************************************************
  // Logical device numbers of the three register sets
  // ***********************************************************
  localparam logic [4:0] CRA_DEV_HUB    = 5'h00;
  localparam logic [4:0] CRA_DEV_GFX    = 5'h01;
  localparam logic [4:0] CRA_DEV_STREAM = 5'h03;

  // ***********************************************************
  // Register dword indices inside each set
  // ***********************************************************
  localparam logic [5:0] CRA_IDX_ID      = 6'h00; // RO identity
  localparam logic [5:0] CRA_IDX_CTRL    = 6'h01; // R/W plus lock bit
  localparam logic [5:0] CRA_IDX_STATUS  = 6'h02; // Write-one-clear
  localparam logic [5:0] CRA_IDX_ONCE    = 6'h03; // Write-once
  localparam logic [5:0] CRA_IDX_STRAP   = 6'h04; // Strap-defaulted R/W
  localparam logic [5:0] CRA_IDX_VENDOR  = 6'h05; // Vendor reserved

  // ***********************************************************
  // Field layout and defaults
  // ***********************************************************
  localparam int          CRA_LOCK_BIT     = 31;
  localparam logic [31:0] CRA_CTRL_LOCKABLE = 32'h0000_FF00; // Bits frozen by lock
  localparam logic [31:0] CRA_CTRL_RSV     = 32'h7FFF_0000;  // Reserved read zero
  localparam logic [31:0] CRA_CTRL_DEF     = 32'h0000_0000;
  localparam logic [31:0] CRA_CTRL_STICKY  = 32'h0000_000F;  // Kept by warm reset
  localparam logic [31:0] CRA_ONCE_DEF     = 32'h0000_0000;
  localparam logic [31:0] CRA_STATUS_DEF   = 32'h0000_0000;
  localparam int          CRA_STRAP_W      = 8;

  // Identity value: arbitrary, names no real part
  localparam logic [31:0] CRA_ID_VALUE     = 32'h5A5A_0001;

endpackage

// [core/cra_regset.sv]
// One logical device register set: RO, R/W lockable, W1C, write-once, strap.
// Assumes byte-lane writes already aligned to a dword by the decoder.
module cra_regset #(
  parameter logic [31:0] ID_VALUE = cra_pkg::CRA_ID_VALUE
) (
  // Clock and resets
  input  wire logic        ref_clk_i,
  input  wire logic        full_rst_i,
  input  wire logic        warm_rst_i,
  // Access
  input  wire logic        wr_i,
  input  wire logic [5:0]  idx_i,
  input  wire logic [3:0]  be_i,
  input  wire logic [31:0] wdata_i,
  // Hardware events and strap defaults
  input  wire logic [31:0] event_i,
  input  wire logic [31:0] strap_val_i,
  // Read data and control register contents
  output logic [31:0]      rdata_o,
  output logic [31:0]      ctrl_o
);

  logic [31:0] ctrl_reg;
  logic [31:0] status_reg;
  logic [31:0] once_reg;
  logic [31:0] once_done_reg;
  logic [31:0] strap_reg;
  logic [31:0] bmask;

  // Byte enables expanded to a bit mask, low byte lowest address
  assign bmask = {{8{be_i[3]}}, {8{be_i[2]}}, {8{be_i[1]}}, {8{be_i[0]}}};

  wire         wr_ctrl   = wr_i && (idx_i == cra_pkg::CRA_IDX_CTRL);
  wire         wr_status = wr_i && (idx_i == cra_pkg::CRA_IDX_STATUS);
  wire         wr_once   = wr_i && (idx_i == cra_pkg::CRA_IDX_ONCE);
  wire         wr_strap  = wr_i && (idx_i == cra_pkg::CRA_IDX_STRAP);
  wire         locked    = ctrl_reg[cra_pkg::CRA_LOCK_BIT];
  wire  [31:0] ctrl_wm   = bmask & ~cra_pkg::CRA_CTRL_RSV &
                           ~(locked ? cra_pkg::CRA_CTRL_LOCKABLE : 32'h0000_0000);
  wire  [31:0] once_wm   = bmask & ~once_done_reg;

  // Control: warm reset keeps sticky bits, full reset clears all
  always_ff @(posedge ref_clk_i or posedge full_rst_i)
    if (full_rst_i)
      ctrl_reg <= cra_pkg::CRA_CTRL_DEF;
    else if (warm_rst_i)
      ctrl_reg <= (ctrl_reg & cra_pkg::CRA_CTRL_STICKY) | (cra_pkg::CRA_CTRL_DEF & ~cra_pkg::CRA_CTRL_STICKY);
    else if (wr_ctrl)
      ctrl_reg <= (ctrl_reg & ~ctrl_wm) | (wdata_i & ctrl_wm);

  // Status: hardware set wins over a same-cycle clear
  always_ff @(posedge ref_clk_i or posedge full_rst_i)
    if (full_rst_i)
      status_reg <= cra_pkg::CRA_STATUS_DEF;
    else if (warm_rst_i)
      status_reg <= cra_pkg::CRA_STATUS_DEF;
    else
      status_reg <= (status_reg & ~(wr_status ? (wdata_i & bmask) : 32'h0000_0000)) | event_i;

  // Write-once bits and their written flags, cleared only by power-up
  always_ff @(posedge ref_clk_i or posedge full_rst_i)
    if (full_rst_i)
    begin
      once_reg      <= cra_pkg::CRA_ONCE_DEF;
      once_done_reg <= 32'h0000_0000;
    end
    else if (wr_once)
    begin
      once_reg      <= (once_reg & ~once_wm) | (wdata_i & once_wm);
      once_done_reg <= once_done_reg | bmask;
    end

  // Strap-defaulted register: reloads its default from the strap value during reset
  always_ff @(posedge ref_clk_i)
    if (full_rst_i || warm_rst_i)
      strap_reg <= strap_val_i;
    else if (wr_strap)
      strap_reg <= (strap_reg & ~bmask) | (wdata_i & bmask);

  // Read selection; unlisted and vendor indices read zero
  always_comb
  begin
    case (idx_i)
      cra_pkg::CRA_IDX_ID:     rdata_o = ID_VALUE;
      cra_pkg::CRA_IDX_CTRL:   rdata_o = ctrl_reg;
      cra_pkg::CRA_IDX_STATUS: rdata_o = status_reg;
      cra_pkg::CRA_IDX_ONCE:   rdata_o = once_reg;
      cra_pkg::CRA_IDX_STRAP:  rdata_o = strap_reg;
      default:                 rdata_o = 32'h0000_0000;
    endcase
  end

  assign ctrl_o = ctrl_reg;

  // ***********************************************************
  // Checks
  // ***********************************************************
  // Locked write leaves the lockable field as it was
  property p_lockfrz;
    @(posedge ref_clk_i) disable iff (full_rst_i || warm_rst_i)
      (wr_ctrl && locked) |=>
        ((ctrl_reg & cra_pkg::CRA_CTRL_LOCKABLE) == ($past(ctrl_reg) & cra_pkg::CRA_CTRL_LOCKABLE));
  endproperty
  a_lockfrz: assert property (p_lockfrz) else $error("locked field changed");

  // Bits already written once keep their value
  property p_oncefrz;
    @(posedge ref_clk_i) disable iff (full_rst_i)
      wr_once |=> ((once_reg & $past(once_done_reg)) == ($past(once_reg) & $past(once_done_reg)));
  endproperty
  a_oncefrz: assert property (p_oncefrz) else $error("written-once bit changed");

  // A hardware event always shows up, even against a clear
  property p_w1cset;
    @(posedge ref_clk_i) disable iff (full_rst_i || warm_rst_i)
      (event_i != 32'h0000_0000) |=> ((status_reg & $past(event_i)) == $past(event_i));
  endproperty
  a_w1cset: assert property (p_w1cset) else $error("event lost to clear");

endmodule

// [core/cra_top.sv]
// Configuration address port and data window decoding for three register sets.
// Assumes host I/O cycles are one-cycle strobes synchronous to ref_clk_i.
module cra_top (
  // Clock and resets
  input  wire logic        ref_clk_i,
  input  wire logic        reset_i,
  input  wire logic        hub_reset_in_n_i,
  input  wire logic        power_good_i,
  // Host I/O cycle
  input  wire logic        io_req_i,
  input  wire logic        io_wr_i,
  input  wire logic [15:0] io_addr_i,
  input  wire logic [3:0]  io_be_i,
  input  wire logic [31:0] io_wdata_i,
  output logic             io_ack_o,
  output logic [31:0]      io_rdata_o,
  // Straps and events
  input  wire logic [7:0]  strap_i,
  input  wire logic [31:0] event_hub_i,
  input  wire logic [31:0] event_gfx_i,
  input  wire logic [31:0] event_stream_i,
  // State
  output logic [31:0]      cfg_addr_o,
  output logic             cfg_cycle_o,
  output logic [31:0]      hub_ctrl_o
);

  // ***********************************************************
  // Resets
  // ***********************************************************
  // Full reset: reset_i high or power-good low; warm: hub reset with power good
  wire full_rst = reset_i || !power_good_i;
  wire warm_rst = !hub_reset_in_n_i && power_good_i;

  // ***********************************************************
  // Decode
  // ***********************************************************
  logic [31:0] addr_reg;
  wire hit_addr = io_req_i && (io_addr_i[15:2] == cra_pkg::CRA_IO_ADDR_PORT[15:2]);
  wire hit_data = io_req_i && (io_addr_i[15:2] == cra_pkg::CRA_IO_DATA_PORT[15:2]);
  wire enabled  = addr_reg[cra_pkg::CRA_ENABLE_BIT];
  wire bus0     = (addr_reg[23:cra_pkg::CRA_BUS_LSB] == 8'h00);
  wire [4:0] dev = addr_reg[15:cra_pkg::CRA_DEV_LSB];
  wire fn0      = (addr_reg[10:cra_pkg::CRA_FUNC_LSB] == 3'h0);
  wire [5:0] idx = addr_reg[7:cra_pkg::CRA_REG_LSB];
  wire cfg_go   = hit_data && enabled;
  wire sel_hub  = cfg_go && bus0 && fn0 && (dev == cra_pkg::CRA_DEV_HUB);
  wire sel_gfx  = cfg_go && bus0 && fn0 && (dev == cra_pkg::CRA_DEV_GFX);
  wire sel_str  = cfg_go && bus0 && fn0 && (dev == cra_pkg::CRA_DEV_STREAM);
  wire [31:0] rd_hub;
  wire [31:0] rd_gfx;
  wire [31:0] rd_str;
  wire [31:0] strap_ext = {24'h000000, strap_i};

  // Address port takes full dword writes only
  always_ff @(posedge ref_clk_i or posedge full_rst)
    if (full_rst)
      addr_reg <= 32'h0000_0000;
    else if (warm_rst)
      addr_reg <= 32'h0000_0000;
    else if (hit_addr && io_wr_i && (io_be_i == 4'hF))
      addr_reg <= io_wdata_i & cra_pkg::CRA_ADDR_KEEP;

  // ***********************************************************
  // Register sets
  // ***********************************************************
  genvar g;
  wire [2:0] sel_v = {sel_str, sel_gfx, sel_hub};
  wire [31:0] rd_v [3];
  wire [31:0] ev_v [3];
  wire [31:0] ctrl_v [3];
  assign ev_v[0] = event_hub_i;
  assign ev_v[1] = event_gfx_i;
  assign ev_v[2] = event_stream_i;
  generate
    for (g = 0; g < 3; g++)
    begin : g_set
      cra_regset u_set (
        .ref_clk_i   (ref_clk_i),
        .full_rst_i  (full_rst),
        .warm_rst_i  (warm_rst),
        .wr_i        (sel_v[g] && io_wr_i && !warm_rst),
        .idx_i       (idx),
        .be_i        (io_be_i),
        .wdata_i     (io_wdata_i),
        .event_i     (ev_v[g]),
        .strap_val_i (strap_ext),
        .rdata_o     (rd_v[g]),
        .ctrl_o      (ctrl_v[g])
      );
    end
  endgenerate
  assign rd_hub = rd_v[0];
  assign rd_gfx = rd_v[1];
  assign rd_str = rd_v[2];

  // ***********************************************************
  // Read answer
  // ***********************************************************
  wire [31:0] rd_sel = sel_hub ? rd_hub : sel_gfx ? rd_gfx : sel_str ? rd_str :
                       hit_addr ? addr_reg : 32'h0000_0000;
  wire [31:0] lane_mask;
  wire [31:0] rd_msk;

  // One byte of mask per enable, lane 0 at the lowest address
  genvar b;
  generate
    for (b = 0; b < 4; b++)
    begin : g_lane
      assign lane_mask[8*b +: 8] = {8{io_be_i[b]}};
    end
  endgenerate

  // Disabled lanes read back as zero
  assign rd_msk = rd_sel & lane_mask;

  // Every cycle completes one clock later, mapped or reserved
  always_ff @(posedge ref_clk_i or posedge reset_i)
    if (reset_i)
    begin
      io_ack_o    <= 1'b0;
      io_rdata_o  <= 32'h0000_0000;
      cfg_cycle_o <= 1'b0;
    end
    else
    begin
      io_ack_o    <= io_req_i;
      io_rdata_o  <= (io_req_i && !io_wr_i) ? rd_msk : 32'h0000_0000;
      cfg_cycle_o <= cfg_go;
    end

  assign cfg_addr_o = addr_reg;
  assign hub_ctrl_o = ctrl_v[0];

  // ***********************************************************
  // Checks
  // ***********************************************************
  property p_ack;
    @(posedge ref_clk_i) disable iff (reset_i) io_req_i |=> io_ack_o;
  endproperty
  a_ack: assert property (p_ack) else $error("cycle not completed");

  property p_noen;
    @(posedge ref_clk_i) disable iff (reset_i) (hit_data && !addr_reg[31]) |=> !cfg_cycle_o;
  endproperty
  a_noen: assert property (p_noen) else $error("config cycle while disabled");

  property p_addrw;
    @(posedge ref_clk_i) disable iff (full_rst || warm_rst)
      (hit_addr && io_wr_i && io_be_i != 4'hF) |=> $stable(addr_reg);
  endproperty
  a_addrw: assert property (p_addrw) else $error("narrow address write took effect");

  property p_rsvrd;
    @(posedge ref_clk_i) disable iff (reset_i)
      (io_req_i && !io_wr_i && !hit_addr && !cfg_go) |=> io_rdata_o == 32'h0000_0000;
  endproperty
  a_rsvrd: assert property (p_rsvrd) else $error("reserved read nonzero");

  // Request shapes shared by the properties below
  sequence s_rd_req;
    io_req_i && !io_wr_i;
  endsequence

  sequence s_addr_load;
    hit_addr && io_wr_i && (io_be_i == 4'hF) && !warm_rst;
  endsequence

  // Window access with the enable bit set raises a config cycle next clock
  property p_cfgcyc;
    @(posedge ref_clk_i) disable iff (reset_i) cfg_go |=> cfg_cycle_o;
  endproperty
  a_cfgcyc: assert property (p_cfgcyc) else $error("config cycle missing");

  // Read answer carries only the enabled byte lanes
  property p_rdlane;
    @(posedge ref_clk_i) disable iff (reset_i)
      s_rd_req |=> ((io_rdata_o & ~$past(lane_mask)) == 32'h0000_0000);
  endproperty
  a_rdlane: assert property (p_rdlane) else $error("disabled lane not zero");

  // Full dword write to the address port lands on the next clock
  property p_addrld;
    @(posedge ref_clk_i) disable iff (full_rst || warm_rst)
      s_addr_load |=> (addr_reg == ($past(io_wdata_i) & cra_pkg::CRA_ADDR_KEEP));
  endproperty
  a_addrld: assert property (p_addrld) else $error("address port write lost");

endmodule

// [verif/cra_host_model.sv]
// Host processor model issuing one-clock I/O strobes to the hub.
// Assumes the hub acknowledges each strobe within a few clocks.
module cra_host_model (
  // Clock
  input  wire logic        ref_clk_i,
  // I/O cycle
  output logic             io_req_o,
  output logic             io_wr_o,
  output logic [15:0]      io_addr_o,
  output logic [3:0]       io_be_o,
  output logic [31:0]      io_wdata_o,
  input  wire logic        io_ack_i,
  input  wire logic [31:0] io_rdata_i
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle bus at time zero
  initial
  begin
    io_req_o = 1'b0;
    io_wr_o = 1'b0;
    io_addr_o = '0;
    io_be_o = '0;
    io_wdata_o = '0;
  end

  // One strobe, then released lines show inverted values while awaiting ack
  task automatic io_cycle(input logic wr, input logic [15:0] addr, input logic [3:0] be,
                          input logic [31:0] wdata, output logic [31:0] rdata, output logic ok);
    int n;
    ok = 1'b0;
    rdata = '0;
    @(posedge ref_clk_i);
    #1;
    io_req_o = 1'b1;
    io_wr_o = wr;
    io_addr_o = addr;
    io_be_o = be;
    io_wdata_o = wdata;
    @(posedge ref_clk_i);
    #1;
    io_req_o = 1'b0;
    io_wr_o = ~wr;
    io_addr_o = ~addr;
    io_be_o = ~be;
    io_wdata_o = ~wdata;
    for (n = 0; n < 4 && !ok; n++)
    begin
      if (io_ack_i === 1'b1)
      begin
        rdata = io_rdata_i;
        ok = 1'b1;
      end
      else
      begin
        @(posedge ref_clk_i);
        #1;
      end
    end
  endtask
endmodule

// [verif/tb_config_register_access_rules.sv]
// Self-checking bench for the configuration register access block.
// Assumes cra_top driven by the host model; straps held constant except while power good is low.
module tb_config_register_access_rules;
  timeunit 1ns;
  timeprecision 1ps;

  // ****
  // Signals and instances
  // ****
  logic        ref_clk_i = 1'b0;
  logic        reset_i   = 1'b1;
  logic        warm_n    = 1'b1;
  logic        pwr_good  = 1'b1;
  logic [31:0] ev_hub    = '0;
  logic [7:0]  strap     = 8'hA5;
  logic        io_req, io_wr, io_ack, cfg_cycle, ok;
  logic [15:0] io_addr;
  logic [3:0]  io_be;
  logic [31:0] io_wdata, io_rdata, cfg_addr, hub_ctrl, rd_val;
  int          mismatches  = 0;
  int          comparisons = 0;

  // Clock of 8 ns
  always #4 ref_clk_i = ~ref_clk_i;

  cra_top u_dut (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .hub_reset_in_n_i(warm_n),
    .power_good_i(pwr_good), .io_req_i(io_req), .io_wr_i(io_wr), .io_addr_i(io_addr),
    .io_be_i(io_be), .io_wdata_i(io_wdata), .io_ack_o(io_ack), .io_rdata_o(io_rdata),
    .strap_i(strap), .event_hub_i(ev_hub), .event_gfx_i(32'h0), .event_stream_i(32'h0),
    .cfg_addr_o(cfg_addr), .cfg_cycle_o(cfg_cycle), .hub_ctrl_o(hub_ctrl));
  cra_host_model u_host (.ref_clk_i(ref_clk_i), .io_req_o(io_req), .io_wr_o(io_wr),
    .io_addr_o(io_addr), .io_be_o(io_be), .io_wdata_o(io_wdata), .io_ack_i(io_ack),
    .io_rdata_i(io_rdata));

  // ****
  // Shared tasks
  // ****
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic stop_test;
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // A lost acknowledge ends the run
  task automatic cyc(input logic wr, input logic [15:0] a, input logic [3:0] be, input logic [31:0] d);
    u_host.io_cycle(wr, a, be, d, rd_val, ok);
    if (!ok)
    begin
      mismatches++;
      stop_test();
    end
  endtask
  // Full dword select of set and index, no read-merge needed here
  task automatic sel(input logic [4:0] dev, input logic [5:0] idx);
    cyc(1'b1, cra_pkg::CRA_IO_ADDR_PORT, 4'hF, 32'h8000_0000 | (32'(dev) << 11) | (32'(idx) << 2));
  endtask
  task automatic wrw(input logic [3:0] be, input logic [31:0] d);
    cyc(1'b1, cra_pkg::CRA_IO_DATA_PORT, be, d);
  endtask
  task automatic rdw(input logic [3:0] be, input logic [31:0] exp);
    cyc(1'b0, cra_pkg::CRA_IO_DATA_PORT, be, 32'h0);
    chk(rd_val, exp);
  endtask

  // ****
  // Scenarios
  // ****
  // Defaults, identity of all three sets, strap-loaded field
  task automatic t_defaults;
    chk(cfg_addr, 32'h0);
    chk(hub_ctrl, cra_pkg::CRA_CTRL_DEF);
    sel(cra_pkg::CRA_DEV_HUB, cra_pkg::CRA_IDX_ID);
    rdw(4'hF, cra_pkg::CRA_ID_VALUE);
    chk({31'h0, cfg_cycle}, 32'h1);
    sel(cra_pkg::CRA_DEV_GFX, cra_pkg::CRA_IDX_ID);
    rdw(4'hF, cra_pkg::CRA_ID_VALUE);
    sel(cra_pkg::CRA_DEV_STREAM, cra_pkg::CRA_IDX_ID);
    rdw(4'hF, cra_pkg::CRA_ID_VALUE);
    sel(cra_pkg::CRA_DEV_HUB, cra_pkg::CRA_IDX_STRAP);
    rdw(4'hF, 32'h0000_00A5);
  endtask
  // Address port contents, narrow write dropped, enable bit clear
  task automatic t_addr_port;
    sel(cra_pkg::CRA_DEV_GFX, cra_pkg::CRA_IDX_CTRL);
    chk(cfg_addr, 32'h8000_0804);
    cyc(1'b1, cra_pkg::CRA_IO_ADDR_PORT, 4'h3, 32'h0);
    cyc(1'b0, cra_pkg::CRA_IO_ADDR_PORT, 4'hF, 32'h0);
    chk(rd_val, 32'h8000_0804);
    cyc(1'b1, cra_pkg::CRA_IO_ADDR_PORT, 4'hF, 32'h0000_0810);
    rdw(4'hF, 32'h0);
    chk({31'h0, cfg_cycle}, 32'h0);
  endtask
  // Byte lanes, little-endian order, reserved and read-only bits
  task automatic t_lanes;
    sel(cra_pkg::CRA_DEV_HUB, cra_pkg::CRA_IDX_CTRL);
    wrw(4'hF, 32'h7FFF_1234);
    rdw(4'hF, 32'h0000_1234);
    wrw(4'h2, 32'hFFFF_ABFF);
    rdw(4'hF, 32'h0000_AB34);
    rdw(4'h2, 32'h0000_AB00);
    sel(cra_pkg::CRA_DEV_HUB, cra_pkg::CRA_IDX_ID);
    wrw(4'hF, 32'h0);
    rdw(4'hF, cra_pkg::CRA_ID_VALUE);
  endtask
  // Status bits set by events, cleared by writing one
  task automatic t_w1c;
    @(posedge ref_clk_i);
    #1 ev_hub = 32'h0000_0003;
    @(posedge ref_clk_i);
    #1 ev_hub = 32'h0;
    sel(cra_pkg::CRA_DEV_HUB, cra_pkg::CRA_IDX_STATUS);
    wrw(4'hF, 32'h0000_0001);
    rdw(4'hF, 32'h0000_0002);
    wrw(4'hF, 32'h0);
    rdw(4'hF, 32'h0000_0002);
    // Event and clear of the same bit in one cycle: the event wins
    ev_hub = 32'h0000_0004;
    wrw(4'hF, 32'h0000_0004);
    ev_hub = 32'h0;
    rdw(4'hF, 32'h0000_0006);
    wrw(4'hF, 32'h0000_0004);
    rdw(4'hF, 32'h0000_0002);
  endtask
  // First write per lane sticks, other lanes stay open
  task automatic t_once;
    sel(cra_pkg::CRA_DEV_HUB, cra_pkg::CRA_IDX_ONCE);
    wrw(4'h1, 32'h0000_0011);
    wrw(4'h1, 32'h0000_0022);
    rdw(4'hF, 32'h0000_0011);
    wrw(4'h2, 32'h0000_3300);
    rdw(4'hF, 32'h0000_3311);
  endtask
  // Read-merge-write that sets the lock, then frozen field
  task automatic t_lock;
    sel(cra_pkg::CRA_DEV_HUB, cra_pkg::CRA_IDX_CTRL);
    cyc(1'b0, cra_pkg::CRA_IO_DATA_PORT, 4'hF, 32'h0);
    wrw(4'hF, (rd_val & 32'h0000_00FF) | 32'h8000_5500);
    wrw(4'hF, 32'h8000_AA34);
    rdw(4'hF, 32'h8000_5534);
  endtask
  // Reserved hub location completes, reads zero, keeps state
  task automatic t_reserved;
    sel(cra_pkg::CRA_DEV_HUB, 6'h07);
    wrw(4'hF, 32'hFFFF_FFFF);
    rdw(4'hF, 32'h0);
    rdw(4'h1, 32'h0);
    rdw(4'h3, 32'h0);
    sel(cra_pkg::CRA_DEV_HUB, cra_pkg::CRA_IDX_VENDOR);
    rdw(4'hF, 32'h0);
    chk(hub_ctrl, 32'h8000_5534);
  endtask
  // Warm reset keeps sticky and write-once bits, full reset restores all defaults
  task automatic t_resets;
    sel(cra_pkg::CRA_DEV_HUB, cra_pkg::CRA_IDX_STRAP);
    wrw(4'h1, 32'h0000_0077);
    rdw(4'hF, 32'h0000_0077);
    @(posedge ref_clk_i);
    #1 warm_n = 1'b0;
    repeat (2) @(posedge ref_clk_i);
    #1 warm_n = 1'b1;
    chk(cfg_addr, 32'h0);
    chk(hub_ctrl, 32'h0000_0004);
    sel(cra_pkg::CRA_DEV_HUB, cra_pkg::CRA_IDX_ONCE);
    rdw(4'hF, 32'h0000_3311);
    sel(cra_pkg::CRA_DEV_HUB, cra_pkg::CRA_IDX_STRAP);
    rdw(4'hF, 32'h0000_00A5);
    @(posedge ref_clk_i);
    #1 pwr_good = 1'b0;
    strap = 8'h3C;
    repeat (2) @(posedge ref_clk_i);
    #1 pwr_good = 1'b1;
    chk(hub_ctrl, 32'h0);
    sel(cra_pkg::CRA_DEV_HUB, cra_pkg::CRA_IDX_STRAP);
    rdw(4'hF, 32'h0000_003C);
    sel(cra_pkg::CRA_DEV_HUB, cra_pkg::CRA_IDX_ONCE);
    wrw(4'h1, 32'h0000_0044);
    rdw(4'hF, 32'h0000_0044);
  endtask

  // Reset for three clocks, then every scenario in turn
  initial
  begin
    repeat (3) @(posedge ref_clk_i);
    #1 reset_i = 1'b0;
    t_defaults();
    t_addr_port();
    t_lanes();
    t_w1c();
    t_once();
    t_lock();
    t_reserved();
    t_resets();
    stop_test();
  end
endmodule
